// [common/spims_pkg.sv]
// Purpose: Types shared by the SPI byte port
// Assumes: Nothing
// Notes:   Constants live in spims_regs.svh
package spims_pkg;
    typedef logic [31:0] spims_word_t;
    typedef logic [7:0]  spims_byte_t;
    typedef enum logic [0:0] {SPIMS_IDLE, SPIMS_RUN} spims_state_t;
endpackage

// [common/spims_regs.svh]
// Purpose: Register map, field positions and timing counts of the SPI byte port
// Assumes: Each register is one aligned 32-bit word on AHB-Lite
// Notes:   Byte data sits in bits 7:0, upper bits read as zero
`ifndef SPIMS_REGS_SVH
`define SPIMS_REGS_SVH
`define SPIMS_OFS_CTRL   2'h0
`define SPIMS_OFS_STAT   2'h1
`define SPIMS_OFS_DATA   2'h2
`define SPIMS_CTRL_RST   8'h00
`define SPIMS_RATE_LO    0
`define SPIMS_RATE_HI    1
`define SPIMS_PHASE      2
`define SPIMS_IDLE_LVL   3
`define SPIMS_MASTER     4
`define SPIMS_ENABLE     6
`define SPIMS_IRQ_EN     7
`define SPIMS_ST_DONE    7
`define SPIMS_ST_WRITE_COLLISION_FLAG    6
`define SPIMS_ST_MODE_FAULT_FLAG    4
`define SPIMS_HALF0      6'h04
`define SPIMS_HALF1      6'h08
`define SPIMS_HALF2      6'h10
`define SPIMS_HALF3      6'h20
`define SPIMS_LAST_EDGE  4'hf
`define SPIMS_PIN_SCK    0
`define SPIMS_PIN_MOSI   1
`define SPIMS_PIN_MISO   2
`define SPIMS_PIN_SS     3
`endif

// [logic/spims_top.sv]
// Purpose: Byte SPI port, master or slave, with AHB-Lite register slave
// Assumes: clock_i 50 MHz; pins arrive unsynchronised; external master obeys limits
// Notes:   Master rates are clock/8, /16, /32, /64
// Summary of operation
// - Shift bytes MSB first, full duplex
// - Exactly eight clock pulses per byte
// - One completion flag, no separate buffer flags
// - Four master rates from two select bits
// - Master drives SCK and MOSI, samples MISO
// - Data write loads shifter and starts master
// - Enabled master: master and enable bits hold only while SS high
// - Set done flag; interrupt if enabled and unmasked
// - Copy received byte to buffer at completion
// - Status access then data read clears done
// - Data writes ignored while done until status read
// - Slave uses SCK, ignores rate bits
// - Slave: MOSI input, MISO output when enabled and SS low
// - Slave shifts out on MISO following SCK
// - Both ends use same polarity and phase
// - Unselected slave leaves bus alone
// - Polarity sets idle level; phase picks sample edge
// - Write during transfer discarded, collision flag set
// - SS low in master: fault, drop enable, master
// - Slave phase clear: SS low freezes data
`timescale 1ns/10ps
`include "spims_regs.svh"
module spims_top #(
    parameter int DW = 8
) (
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    input  wire logic                hsel_i,
    input  wire spims_pkg::spims_word_t haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire spims_pkg::spims_word_t hwdata_i,
    input  wire logic                hready_i,
    output spims_pkg::spims_word_t   hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    input  wire logic                irq_mask_i,
    output logic                     spi_irq_o,
    input  wire logic                sck_i,
    output logic                     sck_o,
    output logic                     sck_oe_n_o,
    input  wire logic                mosi_i,
    output logic                     mosi_o,
    output logic                     mosi_oe_n_o,
    input  wire logic                miso_i,
    output logic                     miso_o,
    output logic                     miso_oe_n_o,
    input  wire logic                ss_n_i
);
    import spims_pkg::*;

    if (DW != 8) begin : g_chk
        $error("spims_top serves byte transfers only");
    end

    logic [3:0]   s1_r;
    logic [3:0]   s2_r;
    spims_state_t st_r;
    spims_state_t st_nxt;
    spims_byte_t  ctrl_r;
    spims_byte_t  ctrl_nxt;
    spims_byte_t  sh_r;
    spims_byte_t  sh_nxt;
    spims_byte_t  rx_r;
    spims_byte_t  rx_nxt;
    logic         out_r;
    logic         out_nxt;
    logic         sck_r;
    logic         sck_nxt;
    logic         skp_r;
    logic [3:0]   cnt_r;
    logic [3:0]   cnt_nxt;
    logic [5:0]   dv_r;
    logic [5:0]   dv_nxt;
    logic         done_r;
    logic         done_nxt;
    logic         write_collision_flag_r;
    logic         write_collision_flag_nxt;
    logic         mode_fault_flag_r;
    logic         mode_fault_flag_nxt;
    logic         arm_r;
    logic         arm_nxt;
    logic         marm_r;
    logic         marm_nxt;
    logic         irq_r;
    logic         irq_nxt;
    logic         aw_r;
    logic [1:0]   aa_r;
    spims_word_t  rd_r;
    spims_word_t  rd_nxt;
    logic         ap;
    logic         en;
    logic         mst;
    logic         pha;
    logic         ss_lo;
    logic         din;
    logic         ev;
    logic         busy;
    logic         wr_data;
    logic         wr_ctrl;
    logic [5:0]   half;
    logic         done_set;
    logic         mode_fault_flag_set;
    logic         write_collision_flag_set;
    logic         clr_flags;

    // Two-stage synchronisers for all pins
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= 4'h8;
            s2_r <= 4'h8;
        end else begin
            s1_r <= {ss_n_i, miso_i, mosi_i, sck_i};
            s2_r <= s1_r;
        end
    end

    assign ap      = hsel_i & htrans_i[1] & hready_i;
    assign en      = ctrl_r[`SPIMS_ENABLE];
    assign mst     = ctrl_r[`SPIMS_MASTER];
    assign pha     = ctrl_r[`SPIMS_PHASE];
    assign ss_lo   = ~s2_r[`SPIMS_PIN_SS];
    assign din     = mst ? s2_r[`SPIMS_PIN_MISO] : s2_r[`SPIMS_PIN_MOSI];
    assign wr_data = aw_r & (aa_r == `SPIMS_OFS_DATA);
    assign wr_ctrl = aw_r & (aa_r == `SPIMS_OFS_CTRL);
    assign busy    = en & (mst ? (st_r == SPIMS_RUN)
                               : (ss_lo & (~pha | (cnt_r != 4'h0))));

    always_comb begin
        case (ctrl_r[`SPIMS_RATE_HI:`SPIMS_RATE_LO])
            2'h0:    half = `SPIMS_HALF0;
            2'h1:    half = `SPIMS_HALF1;
            2'h2:    half = `SPIMS_HALF2;
            default: half = `SPIMS_HALF3;
        endcase
    end

    always_comb begin
        st_nxt    = st_r;
        ctrl_nxt  = ctrl_r;
        sh_nxt    = sh_r;
        rx_nxt    = rx_r;
        out_nxt   = out_r;
        sck_nxt   = sck_r;
        cnt_nxt   = cnt_r;
        dv_nxt    = dv_r;
        arm_nxt   = arm_r;
        marm_nxt  = marm_r;
        rd_nxt    = '0;
        ev        = 1'b0;
        done_set  = 1'b0;
        mode_fault_flag_set  = 1'b0;
        write_collision_flag_set  = 1'b0;
        clr_flags = 1'b0;
        if (st_r == SPIMS_IDLE) begin
            sck_nxt = ctrl_r[`SPIMS_IDLE_LVL];
        end
        // Serial engine
        if (!en) begin
            st_nxt  = SPIMS_IDLE;
            cnt_nxt = 4'h0;
        end else if (mst) begin
            if (ss_lo) begin
                mode_fault_flag_set = 1'b1;
                st_nxt   = SPIMS_IDLE;
                cnt_nxt  = 4'h0;
            end else if (st_r == SPIMS_RUN) begin
                if (dv_r == half - 6'h01) begin
                    dv_nxt  = 6'h00;
                    ev      = 1'b1;
                    sck_nxt = ~sck_r;
                end else begin
                    dv_nxt = dv_r + 6'h01;
                end
            end
        end else if (ss_lo) begin
            if (st_r == SPIMS_IDLE) begin
                out_nxt = sh_r[7];
            end
            st_nxt = SPIMS_RUN;
            ev     = s2_r[`SPIMS_PIN_SCK] != skp_r;
        end else begin
            st_nxt  = SPIMS_IDLE;
            cnt_nxt = 4'h0;
        end
        if (ev) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r[0] == pha) begin
                sh_nxt = {sh_r[6:0], din};
            end else begin
                out_nxt = sh_r[7];
            end
            if (cnt_r == `SPIMS_LAST_EDGE) begin
                done_set = 1'b1;
                rx_nxt   = sh_nxt;
                if (mst) begin
                    st_nxt = SPIMS_IDLE;
                end
            end
        end
        // Register reads and their side effects
        if (ap) begin
            if (haddr_i[3:2] == `SPIMS_OFS_STAT) begin
                if (done_r | write_collision_flag_r) begin
                    arm_nxt = 1'b1;
                end
                if (mode_fault_flag_r) begin
                    marm_nxt = 1'b1;
                end
            end
            if (!hwrite_i) begin
                case (haddr_i[3:2])
                    `SPIMS_OFS_CTRL: rd_nxt = {24'h0, ctrl_r};
                    `SPIMS_OFS_STAT: rd_nxt = {24'h0, done_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
                    `SPIMS_OFS_DATA: rd_nxt = {24'h0, rx_r};
                    default:         rd_nxt = '0;
                endcase
                if ((haddr_i[3:2] == `SPIMS_OFS_DATA) && arm_r) begin
                    clr_flags = 1'b1;
                    arm_nxt   = 1'b0;
                end
            end
        end
        // Register writes
        if (wr_data) begin
            if (done_r && !arm_r) begin
                write_collision_flag_set = 1'b0;
            end else if (busy) begin
                write_collision_flag_set = 1'b1;
            end else begin
                sh_nxt  = hwdata_i[7:0];
                out_nxt = hwdata_i[7];
                if (en && mst) begin
                    st_nxt  = SPIMS_RUN;
                    dv_nxt  = 6'h00;
                    cnt_nxt = 4'h0;
                end
            end
        end
        if (wr_ctrl) begin
            ctrl_nxt = hwdata_i[7:0];
            if (mode_fault_flag_r && !marm_r) begin
                ctrl_nxt[`SPIMS_ENABLE] = 1'b0;
                ctrl_nxt[`SPIMS_MASTER] = 1'b0;
            end
            marm_nxt = 1'b0;
        end
        if (mode_fault_flag_set) begin
            ctrl_nxt[`SPIMS_ENABLE] = 1'b0;
            ctrl_nxt[`SPIMS_MASTER] = 1'b0;
        end
        // Hardware set wins over software clear
        done_nxt = done_set | (done_r & ~clr_flags);
        write_collision_flag_nxt = write_collision_flag_set | (write_collision_flag_r & ~clr_flags);
        mode_fault_flag_nxt = mode_fault_flag_set | (mode_fault_flag_r & ~(wr_ctrl & marm_r));
        irq_nxt  = (done_r | mode_fault_flag_r) & ctrl_r[`SPIMS_IRQ_EN] & ~irq_mask_i;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r   <= SPIMS_IDLE;
            ctrl_r <= `SPIMS_CTRL_RST;
            sh_r   <= 8'h00;
            rx_r   <= 8'h00;
            out_r  <= 1'b0;
            sck_r  <= 1'b0;
            skp_r  <= 1'b0;
            cnt_r  <= 4'h0;
            dv_r   <= 6'h00;
            done_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
            arm_r  <= 1'b0;
            marm_r <= 1'b0;
            irq_r  <= 1'b0;
            aw_r   <= 1'b0;
            aa_r   <= 2'h0;
            rd_r   <= '0;
        end else begin
            st_r   <= st_nxt;
            ctrl_r <= ctrl_nxt;
            sh_r   <= sh_nxt;
            rx_r   <= rx_nxt;
            out_r  <= out_nxt;
            sck_r  <= sck_nxt;
            skp_r  <= s2_r[`SPIMS_PIN_SCK];
            cnt_r  <= cnt_nxt;
            dv_r   <= dv_nxt;
            done_r <= done_nxt;
            write_collision_flag_r <= write_collision_flag_nxt;
            mode_fault_flag_r <= mode_fault_flag_nxt;
            arm_r  <= arm_nxt;
            marm_r <= marm_nxt;
            irq_r  <= irq_nxt;
            aw_r   <= ap & hwrite_i;
            aa_r   <= haddr_i[3:2];
            rd_r   <= rd_nxt;
        end
    end

    assign hrdata_o    = rd_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign spi_irq_o   = irq_r;
    assign sck_o       = sck_r;
    assign mosi_o      = out_r;
    assign miso_o      = out_r;
    assign sck_oe_n_o  = ~(en & mst);
    assign mosi_oe_n_o = ~(en & mst);
    assign miso_oe_n_o = ~(en & ~mst & ss_lo);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    done_on_end_a: assert property (ev && cnt_r == `SPIMS_LAST_EDGE |=> done_r)
        else $error("done flag not set at end of byte");
    rx_copy_a: assert property (ev && cnt_r == `SPIMS_LAST_EDGE
                                |=> rx_r == ($past(pha) ? {$past(sh_r[6:0]), $past(din)}
                                                        : $past(sh_r)))
        else $error("receive buffer not loaded at end of byte");
    wr_ignored_a: assert property (wr_data && done_r && !arm_r && mst
                                   && st_r == SPIMS_IDLE
                                   |=> st_r == SPIMS_IDLE && !$rose(write_collision_flag_r)
                                   && sh_r == $past(sh_r))
        else $error("data write accepted while done flag pending");
    write_collision_flag_set_a: assert property (wr_data && busy && !(done_r && !arm_r)
                                 |=> write_collision_flag_r && (sh_r == $past(sh_r)
                                 || sh_r == {$past(sh_r[6:0]), $past(din)}))
        else $error("collision flag not set or write not discarded");
    mode_fault_a: assert property (en && mst && ss_lo
                                   |=> mode_fault_flag_r && !ctrl_r[`SPIMS_ENABLE] && !mst)
        else $error("mode fault not handled");
    pins_off_a: assert property (!en |-> sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o)
        else $error("disabled port drives a pin");
    byte_len_a: assert property ($rose(st_r == SPIMS_RUN) && mst && !ss_lo
                                 && ctrl_r[`SPIMS_RATE_HI:`SPIMS_RATE_LO] == 2'h0
                                 && $stable(ctrl_r)
                                 |-> ##63 (st_r == SPIMS_RUN || !en || ss_lo)
                                 ##1 (st_r == SPIMS_IDLE))
        else $error("master byte not sixteen half periods");
    sck_idle_a: assert property (mst && st_r == SPIMS_IDLE
                                 && $past(st_r) == SPIMS_IDLE && $stable(ctrl_r)
                                 |-> sck_o == ctrl_r[`SPIMS_IDLE_LVL])
        else $error("clock not at idle level");
    irq_out_a: assert property (done_r && ctrl_r[`SPIMS_IRQ_EN] && !irq_mask_i
                                |=> spi_irq_o)
        else $error("interrupt missing");
    slave_quiet_a: assert property (en && !mst && !ss_lo |-> miso_oe_n_o)
        else $error("unselected slave drives data");
endmodule

// [sim/spims_peer.sv]
// Purpose: Far-end SPI device, slave to the port or master driving it
// Assumes: Mode inputs set to the same timing mode as the port
// Notes:   A released line shows the inverse of its last bit
`timescale 1ns/10ps
module spims_peer (
    input  wire logic       clock_idle_level_i,
    input  wire logic       clock_sample_phase_i,
    input  wire logic       sel_n_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       miso_i,
    input  wire logic [7:0] tx_i,
    output logic            sck_o,
    output logic            mosi_o,
    output logic            miso_o,
    output logic            ss_n_o
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic       mo;
    int         nsamp;
    int         nedge;
    // Rises on the sampling edge for all four modes
    wire        s = sck_i ^ clock_idle_level_i ^ clock_sample_phase_i;
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
        mo = 1'b0;
    end
    assign mosi_o = ss_n_o ? ~mo : mo;
    assign miso_o = sel_n_i ? ~tx_r[7] : tx_r[7];
    always @(negedge sel_n_i) begin
        tx_r = tx_i;
        nsamp = 0;
        nedge = 0;
    end
    always @(sck_i) if (!sel_n_i) nedge++;
    always @(posedge s) if (!sel_n_i) begin
        rx_r = {rx_r[6:0], mosi_i};
        nsamp++;
    end
    always @(negedge s) if (!sel_n_i && nsamp > 0) tx_r = tx_r << 1;
    task automatic mxfer(input logic [7:0] d, output logic [7:0] r);
        // Keep pin changes off the system clock edges
        #5;
        sck_o = clock_idle_level_i;
        mo = d[7];
        #80 ss_n_o = 1'b0;
        #80;
        for (int k = 0; k < 16; k++) begin
            sck_o = ~sck_o;
            if (k[0] == clock_sample_phase_i) r = {r[6:0], miso_i};
            else if (k < 15) mo = d[7 - (k + 1) / 2];
            #80;
        end
        ss_n_o = 1'b1;
    endtask
endmodule

// [sim/spims_top_tb.sv]
// Purpose: Self-checking bench for the SPI byte port
// Assumes: Zero-wait AHB-Lite slave, peer model on the pins
// Notes:   Expected read words travel through one queue
`timescale 1ns/10ps
`include "spims_regs.svh"
module spims_top_tb;
    import spims_pkg::*;
    localparam spims_word_t A_CTRL = {28'h0, `SPIMS_OFS_CTRL, 2'b00};
    localparam spims_word_t A_STAT = {28'h0, `SPIMS_OFS_STAT, 2'b00};
    localparam spims_word_t A_DATA = {28'h0, `SPIMS_OFS_DATA, 2'b00};
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        mask = 1'b0;
    logic        ss_frc = 1'b1;
    logic        clock_idle_level = 1'b0;
    logic        clock_sample_phase = 1'b0;
    logic        sel_n = 1'b1;
    logic        chk_ph = 1'b0;
    logic        sck_q = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  ptx = 8'h00;
    spims_word_t haddr = '0;
    spims_word_t hwdata = '0;
    spims_word_t hrdata;
    spims_word_t expq[$];
    logic        hrdy, hresp, irq, sck_d, sck_oe_n, mosi_d, mosi_oe_n, miso_d, miso_oe_n;
    logic        p_sck, p_mosi, p_miso, p_ss;
    int          errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          half = 0;
    int          tmo = 0;
    wire         sck_w = sck_oe_n ? p_sck : sck_d;
    wire         mosi_w = mosi_oe_n ? p_mosi : mosi_d;
    wire         miso_w = miso_oe_n ? p_miso : miso_d;
    spims_top #(.DW(8)) spims_top_i (
        .clock_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .irq_mask_i(mask), .spi_irq_o(irq), .sck_i(sck_w), .sck_o(sck_d),
        .sck_oe_n_o(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_d),
        .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_d),
        .miso_oe_n_o(miso_oe_n), .ss_n_i(p_ss & ss_frc)
    );
    spims_peer spims_peer_i (
        .clock_idle_level_i(clock_idle_level), .clock_sample_phase_i(clock_sample_phase), .sel_n_i(sel_n), .sck_i(sck_w),
        .mosi_i(mosi_w), .miso_i(miso_w), .tx_i(ptx), .sck_o(p_sck),
        .mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(p_ss)
    );
    always #10 clk = ~clk;
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string nm, input spims_word_t e, input spims_word_t g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single transfer; read words with c set are checked by the monitor below
    task automatic bus(input spims_word_t a, input logic w, input spims_word_t d,
                       input logic c, input spims_word_t e, output spims_word_t r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        chk_ph <= c & ~w;
        if (c & ~w) expq.push_back(e);
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
        chk_ph <= 1'b0;
        hsel <= 1'b0;
    endtask
    task automatic wr(input spims_word_t a, input spims_word_t d);
        spims_word_t r;
        bus(a, 1'b1, d, 1'b0, '0, r);
    endtask
    task automatic rd(input spims_word_t a, input spims_word_t e);
        spims_word_t r;
        bus(a, 1'b0, '0, 1'b1, e, r);
    endtask
    task automatic poll();
        spims_word_t r;
        do bus(A_STAT, 1'b0, '0, 1'b0, '0, r); while (r[7] !== 1'b1);
    endtask
    always @(posedge clk) begin
        if (chk_ph) begin
            cmp("hrdata", expq.pop_front(), hrdata);
            cmp("hresp", 32'h0, {31'h0, hresp});
        end
    end
    // Cycles between serial clock toggles
    always @(posedge clk) begin
        sck_q <= sck_d;
        cyc <= (sck_d !== sck_q) ? 1 : cyc + 1;
        if (sck_d !== sck_q) half <= cyc;
        tmo <= tmo + 1;
        if (tmo == 40000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        logic [7:0] b;
        logic [7:0] e;
        void'($urandom(32'h17fb6176));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(A_CTRL, 32'h0);
        rd(A_STAT, 32'h0);
        rd(32'hc, 32'h0);
        cmp("oe_n", 32'h7, {29'h0, sck_oe_n, mosi_oe_n, miso_oe_n});
        for (int m = 0; m < 4; m++) begin
            b = 8'($urandom);
            ptx <= 8'($urandom);
            mask <= m[0];
            clock_idle_level <= m[1];
            clock_sample_phase <= m[0];
            wr(A_CTRL, {24'h0, 4'hd, m[1], m[0], m[1], m[0]});
            repeat (3) @(posedge clk);
            sel_n <= 1'b0;
            wr(A_DATA, {24'h0, b});
            if (m == 2) begin
                wait (irq === 1'b1);
                wr(A_DATA, 32'h33);
            end
            if (m == 3) begin
                repeat (40) @(posedge clk);
                wr(A_DATA, 32'h5a);
            end
            poll();
            rd(A_STAT, m == 3 ? 32'hc0 : 32'h80);
            cmp("irq", {31'h0, ~mask}, {31'h0, irq});
            cmp("half", 32'(4 << m), 32'(half));
            cmp("sck_idle", {31'h0, clock_idle_level}, {31'h0, sck_d});
            cmp("peer_rx", {24'h0, b}, {24'h0, spims_peer_i.rx_r});
            cmp("edges", 32'd16, 32'(spims_peer_i.nedge));
            rd(A_DATA, {24'h0, ptx});
            sel_n <= 1'b1;
            rd(A_STAT, 32'h0);
        end
        wr(A_CTRL, 32'h50);
        ss_frc <= 1'b0;
        repeat (10) @(posedge clk);
        rd(A_STAT, 32'h10);
        rd(A_CTRL, 32'h0);
        cmp("sck_oe_n", 32'h1, {31'h0, sck_oe_n});
        ss_frc <= 1'b1;
        wr(A_CTRL, 32'h0);
        rd(A_STAT, 32'h0);
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            ptx <= 8'($urandom);
            clock_idle_level <= k[0];
            clock_sample_phase <= k[0];
            wr(A_CTRL, {24'h0, 4'h4, k[0], k[0], 2'h3});
            wr(A_DATA, {24'h0, b});
            if (k == 0) begin
                ss_frc <= 1'b0;
                repeat (4) @(posedge clk);
                wr(A_DATA, {24'h0, ~b});
                ss_frc <= 1'b1;
                repeat (4) @(posedge clk);
            end
            cmp("miso_oe_n", 32'h1, {31'h0, miso_oe_n});
            spims_peer_i.mxfer(ptx, e);
            cmp("slave_tx", {24'h0, b}, {24'h0, e});
            poll();
            rd(A_STAT, k == 0 ? 32'hc0 : 32'h80);
            rd(A_DATA, {24'h0, ptx});
            rd(A_STAT, 32'h0);
        end
        print_verdict();
    end
endmodule
